// [include/serial_port_pkg.sv]
// constants for the serial port control block
// assumes an 8-bit special-function-register bus with page select
package serial_port_pkg;
    // ----------------------------------------
    // register addresses and pages
    // ----------------------------------------
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] ADDR_DATA_BUFFER = 8'h99;
    localparam logic [7:0] ADDR_SERIAL_CONFIG = 8'h9C;
    localparam logic [7:0] ADDR_AUX_TIMER = 8'hA3;
    localparam logic [7:0] ADDR_AUX_PIN = 8'hA4;
    localparam logic [7:0] ADDR_NODE_ADDRESS = 8'hA9;
    localparam logic [7:0] ADDR_CTRL_WINDOW = 8'hB9;
    localparam logic [3:0] PAGE_ZERO = 4'h0;
    localparam logic [3:0] PAGE_AUX_PIN_B = 4'h3;
    // ----------------------------------------
    // reset values and read masks
    // ----------------------------------------
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [6:0] RESET_CONTROL = 7'h00;
    localparam logic [7:0] RESET_CONFIG = 8'h08;
    localparam logic [7:0] CONFIG_READ_MASK = 8'hDF;
    localparam logic [7:0] CTRL2_READ_MASK = 8'hFC;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int PWR_BAUD_DOUBLE = 7;
    localparam int PWR_FE_SELECT = 6;
    localparam int CTL_MODE_MID = 6;
    localparam int CTL_MODE_MULTI = 5;
    localparam int CTL_RX_ENABLE = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;
    localparam int CFG_TIMER_SUB = 7;
    localparam int CFG_EXTRA_DOUBLE = 6;
    localparam int CFG_MODE_HIGH = 4;
    localparam int CFG_BIT_ORDER = 3;
    localparam int CFG_TX_IRQ_BLOCK = 2;
    localparam int CFG_TX_IRQ_SHARE = 1;
    localparam int CFG_WINDOW_SEL = 0;
    localparam int CTRL2_FAST_CLOCK = 6;
    // ----------------------------------------
    // modes, high:low:mid
    // ----------------------------------------
    localparam logic [2:0] MODE_SHIFT = 3'h0;
    localparam logic [2:0] MODE_UART8 = 3'h1;
    localparam logic [2:0] MODE_UART9_FIXED = 3'h2;
    localparam logic [2:0] MODE_UART9_VAR = 3'h3;
    localparam logic [2:0] MODE_SPI = 3'h4;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam logic [3:0] SYNC_HALF_SLOW = 4'h6;
    localparam logic [3:0] SYNC_HALF_FAST = 4'h2;
    localparam logic [2:0] SYNC_LAST_BIT = 3'h7;
    localparam logic [3:0] FIXED_SAMPLE_DIV = 4'h8;
    localparam logic [2:0] VAR_OVF_PER_SAMPLE = 3'h4;
    localparam logic [2:0] SAMPLE_LAST = 3'h7;
    localparam logic [2:0] SAMPLE_MID = 3'h3;
    localparam logic [3:0] FRAME_LAST_8BIT = 4'h9;
    localparam logic [3:0] FRAME_LAST_9BIT = 4'hA;
    localparam logic [3:0] FRAME_NINTH = 4'h9;
    localparam logic [3:0] FRAME_START = 4'h0;
endpackage

// [rtl/serial_port_uart_control.sv]
// serial port control, status and serial engine
// assumes synchronous pins, one sfr access per cycle, reads one cycle late
// What this block does
// - mode bits pick shift, 8-bit, 9-bit, spi or reserved; sync clock sysclk/12 or /4.
// - fixed 9-bit mode runs at sysclk over 64, 32, 16 or 8.
// - control bit 7 is framing error when select set, else mode bit 0.
// - bad stop bit sets framing error always; only software clears it.
// - in shift and spi modes mode bit 2 sets transmit line idle level.
// - 9-bit with mode bit 2: receive flag needs ninth bit one and address match.
// - 8-bit with mode bit 2: receive flag needs valid stop and address match.
// - fast-clock bit with mode bit 2 selects baud generator clock in timer mode.
// - reception only accepted while receive enable is set.
// - in shift and spi modes tx ninth bit picks receive sampling edge.
// - 9-bit sends and captures ninth bit; 8-bit unfiltered captures stop bit.
// - transmit flag at end of 8th bit sync, start of stop otherwise.
// - receive flag at end of 8th bit sync, mid stop otherwise, filtered.
// - one buffer address: write sends, read returns last received byte.
// - given address compares node address under the mask.
// - broadcast address is node address or mask, zeros don't care.
// - baud double doubles rate in 8-bit and 9-bit uart modes.
// - extra double doubles the variable uart rates once more and quadruples the fixed 9-bit rate.
// - timer substitute swaps timer 1 overflow for second port overflow.
// - bit order: 0 msb first, 1 lsb first; timer mode width select.
// - block bit keeps tx flag off port irq; share bit routes it to system irq.
// - window select maps 0xB9 to mask or second control register.
`timescale 1ns/1ps
module serial_port_uart_control (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [3:0] i_sfr_page,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_rx,
    output logic o_tx,
    output logic o_data_out,
    output logic o_data_oe,
    input wire logic i_timer1_overflow,
    input wire logic i_uart1_brg_overflow,
    input wire logic i_timer_mode,
    output logic [1:0] o_brg_clk_select,
    output logic o_brg_wide_timer,
    output logic o_port_irq,
    output logic o_sysflag_irq
);
    typedef enum logic {SY_IDLE, SY_RUN} sync_state_t;
    typedef enum logic {TX_IDLE, TX_RUN} tx_state_t;
    typedef enum logic {RX_IDLE, RX_RUN} rx_state_t;

    logic [7:0] pcon_reg, cfg_reg, auxt_reg, auxa_reg, auxb_reg;
    logic [7:0] node_address_reg, node_address_mask_reg, ctrl2_reg, rxbuf_reg;
    logic [6:0] scon_reg, scon_next;
    logic mode_sel_low_reg, fe_reg;
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire page0 = i_sfr_page == serial_port_pkg::PAGE_ZERO;
    wire hit_pcon = i_sfr_addr == serial_port_pkg::ADDR_POWER_CONTROL;
    wire hit_scon = page0 && i_sfr_addr == serial_port_pkg::ADDR_SERIAL_CONTROL;
    wire hit_buf = page0 && i_sfr_addr == serial_port_pkg::ADDR_DATA_BUFFER;
    wire hit_cfg = page0 && i_sfr_addr == serial_port_pkg::ADDR_SERIAL_CONFIG;
    wire hit_auxt = i_sfr_addr == serial_port_pkg::ADDR_AUX_TIMER;
    wire hit_pin = i_sfr_addr == serial_port_pkg::ADDR_AUX_PIN;
    wire hit_auxa = hit_pin && page0;
    wire hit_auxb = hit_pin && i_sfr_page == serial_port_pkg::PAGE_AUX_PIN_B;
    wire hit_node_address = i_sfr_addr == serial_port_pkg::ADDR_NODE_ADDRESS;
    wire hit_win = i_sfr_addr == serial_port_pkg::ADDR_CTRL_WINDOW;
    wire win_ctrl2 = cfg_reg[serial_port_pkg::CFG_WINDOW_SEL];
    wire wr_scon = i_sfr_wr && hit_scon;
    wire wr_buf = i_sfr_wr && hit_buf;
    wire wr_node_address_mask = i_sfr_wr && hit_win && !win_ctrl2;
    wire wr_ctrl2 = i_sfr_wr && hit_win && win_ctrl2;
    // ----------------------------------------
    // mode and option decode
    // ----------------------------------------
    wire fe_sel = pcon_reg[serial_port_pkg::PWR_FE_SELECT];
    wire dbl1 = pcon_reg[serial_port_pkg::PWR_BAUD_DOUBLE];
    wire dbl2 = cfg_reg[serial_port_pkg::CFG_EXTRA_DOUBLE];
    wire mode_sel_multi = scon_reg[serial_port_pkg::CTL_MODE_MULTI];
    wire ren = scon_reg[serial_port_pkg::CTL_RX_ENABLE];
    wire tb8 = scon_reg[serial_port_pkg::CTL_TX_NINTH];
    wire ti = scon_reg[serial_port_pkg::CTL_TX_DONE];
    wire ri = scon_reg[serial_port_pkg::CTL_RX_DONE];
    wire lsb_first = cfg_reg[serial_port_pkg::CFG_BIT_ORDER];
    wire [2:0] mode = {cfg_reg[serial_port_pkg::CFG_MODE_HIGH], mode_sel_low_reg,
        scon_reg[serial_port_pkg::CTL_MODE_MID]};
    // reserved codes and timer mode keep every engine idle
    wire is_sync = !i_timer_mode && (mode == serial_port_pkg::MODE_SHIFT
        || mode == serial_port_pkg::MODE_SPI);
    wire is_m1 = !i_timer_mode && mode == serial_port_pkg::MODE_UART8;
    wire is_m2 = !i_timer_mode && mode == serial_port_pkg::MODE_UART9_FIXED;
    wire is_9 = is_m2 || (!i_timer_mode && mode == serial_port_pkg::MODE_UART9_VAR);
    wire is_async = is_m1 || is_9;
    wire [7:0] tx_ord = lsb_first ? i_sfr_wdata : {<<{i_sfr_wdata}};
    // ----------------------------------------
    // sample tick, eight per bit
    // ----------------------------------------
    logic [3:0] fix_cnt_reg;
    logic [2:0] ovf_cnt_reg;
    wire [1:0] fix_shift = {dbl2, dbl1};
    wire [3:0] fix_div = serial_port_pkg::FIXED_SAMPLE_DIV >> fix_shift;
    wire fix_tick = fix_cnt_reg >= fix_div - 4'h1;
    // both doublings together are capped at the fastest rate
    wire [1:0] var_shift = (dbl1 && dbl2) ? 2'h2 : {1'b0, dbl1 | dbl2};
    wire [2:0] var_div = serial_port_pkg::VAR_OVF_PER_SAMPLE >> var_shift;
    wire ovf = cfg_reg[serial_port_pkg::CFG_TIMER_SUB]
        ? i_uart1_brg_overflow : i_timer1_overflow;
    wire var_tick = ovf && ovf_cnt_reg >= var_div - 3'h1;
    wire os_tick = is_m2 ? fix_tick : var_tick;
    always_ff @(posedge i_clk) begin
        if (i_reset || fix_tick) begin
            fix_cnt_reg <= 4'h0;
        end else begin
            fix_cnt_reg <= fix_cnt_reg + 4'h1;
        end
        if (i_reset || var_tick) begin
            ovf_cnt_reg <= 3'h0;
        end else if (ovf) begin
            ovf_cnt_reg <= ovf_cnt_reg + 3'h1;
        end
    end
    // ----------------------------------------
    // synchronous shift engine
    // ----------------------------------------
    sync_state_t sy_state_reg;
    logic sy_rx_reg, sy_phase_reg;
    logic [2:0] sy_bit_reg;
    logic [3:0] sy_div_reg;
    logic [7:0] sy_sh_reg;
    wire sy_run = sy_state_reg == SY_RUN;
    wire [3:0] sy_half = dbl1 ? serial_port_pkg::SYNC_HALF_FAST
        : serial_port_pkg::SYNC_HALF_SLOW;
    wire sy_term = sy_run && sy_div_reg == sy_half - 4'h1;
    wire sy_bit_end = sy_term && sy_phase_reg;
    wire sy_done = sy_bit_end && sy_bit_reg == serial_port_pkg::SYNC_LAST_BIT;
    wire sy_start_tx = is_sync && !sy_run && wr_buf;
    wire sy_start_rx = is_sync && !sy_run && !wr_buf && ren && !ri;
    wire sy_lead = sy_rx_reg && tb8 && sy_bit_end && !sy_done;
    wire sy_trail = sy_rx_reg && !tb8 && sy_term && !sy_phase_reg;
    wire idle_lvl = !mode_sel_multi;
    wire sy_clk = (sy_run && !sy_phase_reg) ? !idle_lvl : idle_lvl;
    always_ff @(posedge i_clk) begin
        if (i_reset || !is_sync || sy_done) begin
            sy_state_reg <= SY_IDLE;
        end else if (sy_start_tx || sy_start_rx) begin
            sy_state_reg <= SY_RUN;
        end
        if (sy_start_tx || sy_start_rx) begin
            sy_rx_reg <= !sy_start_tx;
            sy_phase_reg <= 1'b0;
            sy_bit_reg <= 3'h0;
            sy_div_reg <= 4'h0;
            // leading-edge sampling takes its first bit as the clock starts
            sy_sh_reg <= sy_start_tx ? tx_ord : {tb8 & i_rx, 7'h00};
        end else if (sy_run) begin
            sy_div_reg <= sy_term ? 4'h0 : sy_div_reg + 4'h1;
            if (sy_term) begin
                sy_phase_reg <= !sy_phase_reg;
            end
            if (sy_bit_end) begin
                sy_bit_reg <= sy_bit_reg + 3'h1;
            end
            if (sy_lead || sy_trail || (!sy_rx_reg && sy_bit_end)) begin
                sy_sh_reg <= {i_rx, sy_sh_reg[7:1]};
            end
        end
    end
    // ----------------------------------------
    // asynchronous transmitter
    // ----------------------------------------
    tx_state_t tx_state_reg;
    logic [2:0] tx_os_reg;
    logic [3:0] tx_idx_reg;
    logic [9:0] tx_sh_reg;
    logic tx_line_reg;
    wire tx_run = tx_state_reg == TX_RUN;
    wire [3:0] frame_last = is_9 ? serial_port_pkg::FRAME_LAST_9BIT
        : serial_port_pkg::FRAME_LAST_8BIT;
    wire tx_start = is_async && !tx_run && wr_buf;
    wire tx_bit_end = tx_run && os_tick && tx_os_reg == serial_port_pkg::SAMPLE_LAST;
    wire tx_finish = tx_bit_end && tx_idx_reg == frame_last;
    wire tx_at_stop = tx_bit_end && tx_idx_reg + 4'h1 == frame_last;
    always_ff @(posedge i_clk) begin
        if (i_reset || !is_async || tx_finish) begin
            tx_state_reg <= TX_IDLE;
            tx_line_reg <= 1'b1;
        end else if (tx_start) begin
            tx_state_reg <= TX_RUN;
            tx_line_reg <= 1'b0;
            tx_os_reg <= 3'h0;
            tx_idx_reg <= serial_port_pkg::FRAME_START;
            tx_sh_reg <= {1'b1, is_9 ? tb8 : 1'b1, tx_ord};
        end else if (tx_run && os_tick) begin
            tx_os_reg <= tx_os_reg + 3'h1;
            if (tx_bit_end) begin
                tx_idx_reg <= tx_idx_reg + 4'h1;
                tx_line_reg <= tx_sh_reg[0];
                tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
            end
        end
    end
    // ----------------------------------------
    // asynchronous receiver
    // ----------------------------------------
    rx_state_t rx_state_reg;
    logic rx_prev_reg, rx_ninth_reg;
    logic [2:0] rx_os_reg;
    logic [3:0] rx_idx_reg;
    logic [7:0] rx_sh_reg;
    wire rx_run = rx_state_reg == RX_RUN;
    wire rx_start = is_async && !rx_run && ren && rx_prev_reg && !i_rx;
    wire rx_mid = rx_run && os_tick && rx_os_reg == serial_port_pkg::SAMPLE_MID;
    wire rx_false = rx_mid && rx_idx_reg == serial_port_pkg::FRAME_START && i_rx;
    wire rx_finish = rx_mid && rx_idx_reg == frame_last;
    wire rx_data_bit = rx_idx_reg != serial_port_pkg::FRAME_START
        && rx_idx_reg < serial_port_pkg::FRAME_NINTH;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rx_prev_reg <= 1'b1;
        end else begin
            rx_prev_reg <= i_rx;
        end
        if (i_reset || !is_async || rx_false || rx_finish) begin
            rx_state_reg <= RX_IDLE;
        end else if (rx_start) begin
            rx_state_reg <= RX_RUN;
            rx_os_reg <= 3'h0;
            rx_idx_reg <= serial_port_pkg::FRAME_START;
        end else if (rx_run && os_tick) begin
            rx_os_reg <= rx_os_reg + 3'h1;
            if (rx_mid) begin
                rx_idx_reg <= rx_idx_reg + 4'h1;
                if (rx_data_bit) begin
                    rx_sh_reg <= {i_rx, rx_sh_reg[7:1]};
                end
                if (rx_idx_reg == serial_port_pkg::FRAME_NINTH) begin
                    rx_ninth_reg <= i_rx;
                end
            end
        end
    end
    // ----------------------------------------
    // address filter and flag events
    // ----------------------------------------
    wire [7:0] sy_byte = lsb_first ? sy_sh_reg : {<<{sy_sh_reg}};
    wire [7:0] as_byte = lsb_first ? rx_sh_reg : {<<{rx_sh_reg}};
    wire [7:0] bcast_addr = node_address_reg | node_address_mask_reg;
    wire given_hit = ((as_byte ^ node_address_reg) & node_address_mask_reg) == 8'h00;
    wire bcast_hit = (as_byte & bcast_addr) == bcast_addr;
    wire addr_hit = given_hit || bcast_hit;
    wire stop_ok = i_rx;
    wire filter_ok = !mode_sel_multi || (addr_hit && (is_9 ? rx_ninth_reg : stop_ok));
    // a byte that arrives while the flag is still up is dropped
    wire as_accept = rx_finish && !ri && filter_ok;
    wire sy_rx_done = sy_done && sy_rx_reg;
    wire ti_set = tx_at_stop || (sy_done && !sy_rx_reg);
    wire ri_set = as_accept || sy_rx_done;
    wire fe_set = rx_finish && !stop_ok;
    wire rb8_load = as_accept && (is_9 || !mode_sel_multi);
    wire rb8_val = is_9 ? rx_ninth_reg : stop_ok;
    always_comb begin
        scon_next = scon_reg;
        if (wr_scon) begin
            scon_next = i_sfr_wdata[6:0];
        end
        if (rb8_load) begin
            scon_next[serial_port_pkg::CTL_RX_NINTH] = rb8_val;
        end
        if (ti_set) begin
            scon_next[serial_port_pkg::CTL_TX_DONE] = 1'b1;
        end
        if (ri_set) begin
            scon_next[serial_port_pkg::CTL_RX_DONE] = 1'b1;
        end
    end
    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pcon_reg <= serial_port_pkg::RESET_ZERO;
            scon_reg <= serial_port_pkg::RESET_CONTROL;
            mode_sel_low_reg <= 1'b0;
            fe_reg <= 1'b0;
            cfg_reg <= serial_port_pkg::RESET_CONFIG;
            auxt_reg <= serial_port_pkg::RESET_ZERO;
            auxa_reg <= serial_port_pkg::RESET_ZERO;
            auxb_reg <= serial_port_pkg::RESET_ZERO;
            node_address_reg <= serial_port_pkg::RESET_ZERO;
            node_address_mask_reg <= serial_port_pkg::RESET_ZERO;
            ctrl2_reg <= serial_port_pkg::RESET_ZERO;
        end else begin
            scon_reg <= scon_next;
            if (wr_scon && !fe_sel) begin
                mode_sel_low_reg <= i_sfr_wdata[7];
            end
            if (fe_set) begin
                fe_reg <= 1'b1;
            end else if (wr_scon && fe_sel) begin
                fe_reg <= i_sfr_wdata[7];
            end
            if (i_sfr_wr && hit_pcon) begin
                pcon_reg <= i_sfr_wdata;
            end
            if (i_sfr_wr && hit_cfg) begin
                cfg_reg <= i_sfr_wdata;
            end
            if (i_sfr_wr && hit_auxt) begin
                auxt_reg <= i_sfr_wdata;
            end
            if (i_sfr_wr && hit_auxa) begin
                auxa_reg <= i_sfr_wdata;
            end
            if (i_sfr_wr && hit_auxb) begin
                auxb_reg <= i_sfr_wdata;
            end
            if (i_sfr_wr && hit_node_address) begin
                node_address_reg <= i_sfr_wdata;
            end
            if (wr_node_address_mask) begin
                node_address_mask_reg <= i_sfr_wdata;
            end
            if (wr_ctrl2) begin
                ctrl2_reg <= i_sfr_wdata;
            end
        end
        // data buffer content is left undefined by reset
        if (ri_set) begin
            rxbuf_reg <= sy_rx_done ? sy_byte : as_byte;
        end
    end
    // ----------------------------------------
    // read path and outputs
    // ----------------------------------------
    wire [7:0] win_data = win_ctrl2 ? (ctrl2_reg & serial_port_pkg::CTRL2_READ_MASK)
        : node_address_mask_reg;
    wire [7:0] rd_data = hit_pcon ? pcon_reg
        : hit_scon ? {fe_sel ? fe_reg : mode_sel_low_reg, scon_reg}
        : hit_buf ? rxbuf_reg
        : hit_cfg ? (cfg_reg & serial_port_pkg::CONFIG_READ_MASK)
        : hit_auxt ? auxt_reg
        : hit_auxa ? auxa_reg
        : hit_auxb ? auxb_reg
        : hit_node_address ? node_address_reg
        : hit_win ? win_data
        : 8'h00;
    wire tx_next = is_sync ? sy_clk : (is_async ? tx_line_reg : 1'b1);
    wire port_irq_next = ri || (ti && !cfg_reg[serial_port_pkg::CFG_TX_IRQ_BLOCK]);
    wire sys_irq_next = ti && cfg_reg[serial_port_pkg::CFG_TX_IRQ_SHARE];
    wire [1:0] brg_sel_next = {ctrl2_reg[serial_port_pkg::CTRL2_FAST_CLOCK], mode_sel_multi};
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sfr_rdata <= 8'h00;
            o_tx <= 1'b1;
            o_data_out <= 1'b1;
            o_data_oe <= 1'b0;
            o_port_irq <= 1'b0;
            o_sysflag_irq <= 1'b0;
            o_brg_clk_select <= 2'h0;
            o_brg_wide_timer <= 1'b0;
        end else begin
            if (i_sfr_rd) begin
                o_sfr_rdata <= rd_data;
            end
            o_tx <= tx_next;
            o_data_out <= sy_run ? sy_sh_reg[0] : 1'b1;
            o_data_oe <= sy_run && !sy_rx_reg;
            o_port_irq <= port_irq_next;
            o_sysflag_irq <= sys_irq_next;
            o_brg_clk_select <= i_timer_mode ? brg_sel_next : 2'h0;
            o_brg_wide_timer <= i_timer_mode && lsb_first;
        end
    end
endmodule

// [sim/serial_port_uart_control_assertions.sv]
// port assertions for the serial port control block
// assumes one clock domain and the bind below
`timescale 1ns/1ps
module serial_port_uart_control_assertions (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [3:0] i_sfr_page,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_tx,
    input wire logic o_data_out,
    input wire logic o_data_oe,
    input wire logic i_timer_mode,
    input wire logic [1:0] o_brg_clk_select,
    input wire logic o_brg_wide_timer,
    input wire logic o_sysflag_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // ----
    // checks
    // ----
    chk_reset_idle: assert property ($fell(i_reset) |-> o_tx && !o_data_oe && o_sfr_rdata == 8'h00)
        else $error("outputs not idle after reset");
    chk_brg_select: assert property (!i_timer_mode |=> o_brg_clk_select == 2'h0)
        else $error("clock select outside timer mode");
    chk_wide_timer: assert property (!i_timer_mode |=> !o_brg_wide_timer)
        else $error("wide timer outside timer mode");
    chk_unmapped_read: assert property (i_sfr_rd && i_sfr_addr == 8'h33 |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data moved");
    chk_data_idle: assert property (!o_data_oe |-> o_data_out)
        else $error("data line low while idle");
    chk_oe_span: assert property ($rose(o_data_oe) |-> o_data_oe [*8])
        else $error("sync transfer too short");
    chk_clock_runs: assert property ($rose(o_data_oe) |-> ##[0:13] $changed(o_tx))
        else $error("serial clock stuck");
    chk_share_off: assert property (i_sfr_wr && i_sfr_addr == 8'h9C && i_sfr_page == 4'h0
        && !i_sfr_wdata[1] |=> ##1 !o_sysflag_irq)
        else $error("system irq with sharing off");
endmodule
bind serial_port_uart_control serial_port_uart_control_assertions u_chk (.i_clk(i_clk),
    .i_reset(i_reset), .i_sfr_addr(i_sfr_addr), .i_sfr_page(i_sfr_page), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_tx(o_tx),
    .o_data_out(o_data_out), .o_data_oe(o_data_oe), .i_timer_mode(i_timer_mode),
    .o_brg_clk_select(o_brg_clk_select), .o_brg_wide_timer(o_brg_wide_timer),
    .o_sysflag_irq(o_sysflag_irq));

// [sim/remote_node.sv]
// remote serial node on the transmit and receive lines
// assumes eight clocks a bit on both lines
`timescale 1ns/1ps
module remote_node (
    input wire logic i_clk,
    input wire logic i_tx,
    output logic o_rx
);
    // ----
    // line driver and sampler
    // ----
    initial o_rx = 1'b1;
    task automatic send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            o_rx <= f[i];
            repeat (8) @(posedge i_clk); // fastest fixed rate
        end
        o_rx <= 1'b1;
    endtask
    // sampled on the falling edge, clear of the launch edge
    task automatic take(output logic [10:0] f);
        for (int n = 0; n < 100 && i_tx; n++) @(negedge i_clk);
        repeat (4) @(negedge i_clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = i_tx;
            repeat (8) @(negedge i_clk);
        end
    endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the serial port control block
// assumes the remote node model and the checker file
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb;
    logic clk, rst, wr, rd, rx, tx, dout, doe, tmode, pirq, sirq, wide, ovf;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] bsel;
    int bad_count, samples_checked;
    serial_port_uart_control u_serial_port_uart_control (.i_clk(clk), .i_reset(rst),
        .i_sfr_addr(addr), .i_sfr_page(4'h0), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
        .o_sfr_rdata(rdata), .i_rx(rx), .o_tx(tx), .o_data_out(dout), .o_data_oe(doe),
        .i_timer1_overflow(1'b0), .i_uart1_brg_overflow(ovf), .i_timer_mode(tmode),
        .o_brg_clk_select(bsel), .o_brg_wide_timer(wide), .o_port_irq(pirq),
        .o_sysflag_irq(sirq));
    remote_node u_remote_node (.i_clk(clk), .i_tx(tx), .o_rx(rx));
    // ----
    // tasks
    // ----
    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        @(posedge clk) d = rdata;
    endtask
    function automatic logic [10:0] frame(input logic [7:0] b, input logic n, s, lsb);
        logic [7:0] o;
        o = lsb ? b : {<<{b}};
        return {s, n, o, 1'b0};
    endfunction
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial begin
        logic [7:0] d, b;
        logic [10:0] f;
        static logic [7:0] ctl [5] = '{8'h90, 8'h80, 8'hB0, 8'hB0, 8'hB0};
        static logic [7:0] rb [5] = '{8'h00, 8'h00, 8'h5A, 8'h5A, 8'h33};
        static logic [4:0] rn = 5'b11011;
        static logic [4:0] re = 5'b01001;
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        tmode = 1'b0;
        ovf = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        void'($urandom(84806));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(8'h9C, d);
        `CHK("serial_configuration", 8'h08, d)
        rd_reg(8'h33, d);
        `CHK("unmapped", 8'h00, d)
        wr_reg(8'h87, 8'h80);
        wr_reg(8'h98, 8'h98);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            wr_reg(8'h9C, {4'h4, i[0], 3'h2});
            wr_reg(8'h99, b);
            u_remote_node.take(f);
            `CHK("tx_frame", frame(b, 1'b1, 1'b1, i[0]), f)
            rd_reg(8'h98, d);
            `CHK("tx_done", 1'b1, d[1])
            `CHK("sysflag_irq", 1'b1, sirq)
            `CHK("port_irq", 1'b1, pirq)
            wr_reg(8'h98, 8'h98);
        end
        wr_reg(8'hA9, 8'h5A);
        wr_reg(8'hB9, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            b = (i < 2) ? 8'($urandom) : rb[i];
            wr_reg(8'h98, ctl[i]);
            u_remote_node.send(frame(b, rn[i], 1'b1, 1'b1));
            rd_reg(8'h98, d);
            `CHK("rx_done", re[i], d[0])
            if (re[i]) `CHK("rx_ninth", 1'b1, d[2])
            rd_reg(8'h99, d);
            if (re[i]) `CHK("rx_byte", b, d)
        end
        wr_reg(8'h87, 8'hC0);
        wr_reg(8'h98, 8'h30);
        rd_reg(8'h98, d);
        `CHK("fe_view", 1'b0, d[7])
        u_remote_node.send(frame(8'h55, 1'b1, 1'b0, 1'b1));
        rd_reg(8'h98, d);
        `CHK("framing_error", 1'b1, d[7])
        wr_reg(8'h87, 8'h80);
        // 8-bit frame paced by the second port's overflow
        ovf <= 1'b1;
        wr_reg(8'h98, 8'h60);
        wr_reg(8'h9C, 8'hCA);
        b = 8'($urandom);
        wr_reg(8'h99, b);
        u_remote_node.take(f);
        `CHK("uart8_frame", frame(b, 1'b1, 1'b1, 1'b1), f)
        wr_reg(8'h9C, 8'h4B);
        wr_reg(8'hB9, 8'h43);
        rd_reg(8'hB9, d);
        `CHK("serial_ctrl_second", 8'h40, d)
        wr_reg(8'h9C, 8'h4A);
        rd_reg(8'hB9, d);
        `CHK("node_address_mask", 8'hFF, d)
        tmode <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("brg_select", 2'h3, bsel)
        `CHK("brg_wide", 1'b1, wide)
        tmode <= 1'b0;
        wr_reg(8'h98, 8'h20);
        @(posedge clk);
        `CHK("sync_idle", 1'b0, tx)
        wr_reg(8'h99, 8'($urandom));
        repeat (40) @(posedge clk);
        rd_reg(8'h98, d);
        `CHK("sync_tx_done", 1'b1, d[1])
        wr_reg(8'h9C, 8'h5C);
        @(posedge clk);
        `CHK("port_irq_blocked", 1'b0, pirq)
        `CHK("sysflag_irq_off", 1'b0, sirq)
        wr_reg(8'h98, 8'h00);
        wr_reg(8'h9C, 8'h5A);
        wr_reg(8'h98, 8'h80);
        wr_reg(8'h99, 8'hA5);
        repeat (20) @(posedge clk);
        rd_reg(8'h98, d);
        `CHK("reserved_flags", 8'h80, d)
        `CHK("reserved_tx", 1'b1, tx)
        summarize();
    end
endmodule
